//--- hw/se_regs_pkg.sv
package se_regs_pkg;
	// Group 0 register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_LIVE_STATUS = 8'h14;
	localparam logic [7:0] OFS_FIFO_LEVEL = 8'h18;
	localparam logic [7:0] OFS_LEGACY_FIFO = 8'h1c;
	// Group 1 register byte offsets
	localparam logic [7:0] OFS_CMD_RING = 8'h0c;
	localparam logic [7:0] OFS_SRC_RING = 8'h1c;
	// Status bit positions shared by status, mask and live registers
	localparam int BIT_INVALID_CMD = 15;
	localparam int BIT_DATA_ERR = 14;
	localparam int BIT_SRC_RDY = 13;
	localparam int BIT_DST_RDY = 12;
	localparam int BIT_DST_OVERRUN = 9;
	localparam int BIT_SRC_CMD = 7;
	localparam int BIT_SRC_CTX = 6;
	localparam int BIT_SRC_DATA = 5;
	localparam int BIT_DST_DATA = 4;
	localparam int BIT_DST_RESULT = 2;
	// Implemented bits of the status layout; all others read zero
	localparam logic [31:0] STATUS_MASK = 32'h0000_f2f4;
	// Identification request bit in the configuration register
	localparam int BIT_ID_REQ = 5;
	// Configuration register writable bits
	localparam logic [31:0] CONFIG_MASK = 32'h0000_03fe;
	// FIFO level field positions
	localparam int SRC_FREE_LSB = 8;
	localparam int DST_FILL_LSB = 0;
	localparam int LEVEL_W = 7;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_FIFO_LEVEL = 32'h0000_4040;
	// Ring pointers keep only dword addresses
	localparam logic [31:0] RING_MASK = 32'hffff_fffc;
	// Bus access request
	typedef struct packed {
		logic valid;
		logic write;
		logic group1;
		logic from_cpu;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
endpackage

//--- hw/se_regs.sv
`timescale 1ns/1ns
module se_regs #(
	parameter logic [31:0] IDENTIFICATION_REQUEST = 32'h0000_0a5a // Arbitrary value
) (
	input wire logic clk, // 100 MHz engine clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire se_regs_pkg::bus_req_t req, // Register access request
	output logic [31:0] rdata, // Read data, registered
	output logic rvalid, // Read data valid pulse
	input wire logic protected_mode, // Protected mode level
	input wire logic ev_invalid_cmd, // Illegal command event
	input wire logic ev_data_err, // Data register misuse event
	input wire logic ev_dst_overrun, // Destination overrun event
	input wire logic src_rdy, // Source FIFO ready level
	input wire logic dst_rdy, // Dest FIFO ready level
	input wire logic [2:0] src_phase, // Command, context, data phase
	input wire logic [1:0] dst_phase, // Data, result phase
	input wire logic [6:0] src_free, // Source FIFO free bytes
	input wire logic [6:0] dst_fill, // Dest FIFO held bytes
	input wire logic ring_adv_cmd, // DMA fetched a command descriptor
	input wire logic ring_adv_src, // DMA fetched a source descriptor
	output logic [31:0] cmd_ring_ptr, // Next command descriptor
	output logic [31:0] src_ring_ptr, // Next source descriptor
	output logic irq // Engine interrupt request
);
	// Reset release synchroniser
	logic rst_s1_reg;
	logic rst_s2_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	wire logic rsn = rst_s2_reg;

	// Access qualification
	wire logic rd = req.valid && !req.write;
	wire logic wr = req.valid && req.write;
	// Host bus blocked from every register in protected mode
	wire logic host_blk = protected_mode && !req.from_cpu;
	wire logic g0 = !req.group1;
	wire logic g1 = req.group1;
	wire logic hit_cfg = g0 && req.addr == se_regs_pkg::OFS_CONFIG && !host_blk;
	wire logic hit_sts = g0 && req.addr == se_regs_pkg::OFS_IRQ_STATUS && !host_blk;
	wire logic hit_msk = g0 && req.addr == se_regs_pkg::OFS_IRQ_MASK && !host_blk;
	wire logic hit_live = g0 && req.addr == se_regs_pkg::OFS_LIVE_STATUS && !host_blk;
	wire logic hit_lvl = g0 && req.addr == se_regs_pkg::OFS_FIFO_LEVEL && !host_blk;
	wire logic hit_leg = g0 && req.addr == se_regs_pkg::OFS_LEGACY_FIFO && !host_blk;
	wire logic hit_cmdr = g1 && req.addr == se_regs_pkg::OFS_CMD_RING && !host_blk;
	wire logic hit_srcr = g1 && req.addr == se_regs_pkg::OFS_SRC_RING && !host_blk;

	// Live status assembled from engine levels, no latching
	logic [31:0] live;
	always_comb begin
		live = '0;
		live[se_regs_pkg::BIT_SRC_RDY] = src_rdy;
		live[se_regs_pkg::BIT_DST_RDY] = dst_rdy;
		live[se_regs_pkg::BIT_INVALID_CMD] = ev_invalid_cmd;
		live[se_regs_pkg::BIT_DATA_ERR] = ev_data_err;
		live[se_regs_pkg::BIT_DST_OVERRUN] = ev_dst_overrun;
		live[se_regs_pkg::BIT_SRC_CMD] = src_phase[2];
		live[se_regs_pkg::BIT_SRC_CTX] = src_phase[1];
		live[se_regs_pkg::BIT_SRC_DATA] = src_phase[0];
		live[se_regs_pkg::BIT_DST_DATA] = dst_phase[1];
		live[se_regs_pkg::BIT_DST_RESULT] = dst_phase[0];
	end

	// Registers
	logic [31:0] cfg_reg;
	logic [31:0] sts_reg;
	logic [31:0] msk_reg;
	logic [31:0] leg_reg;
	logic [31:0] lvl_reg;
	logic [31:0] live_reg;

	// Write-one-to-clear; a new event in the same cycle wins
	wire logic [31:0] sts_clr = (wr && hit_sts) ? req.wdata : 32'h0000_0000;
	wire logic [31:0] sts_next = ((sts_reg & ~sts_clr) | live) & se_regs_pkg::STATUS_MASK;
	// Identification request self-clears after a live status read
	wire logic id_req = cfg_reg[se_regs_pkg::BIT_ID_REQ];
	wire logic live_rd = rd && hit_live;
	logic [31:0] cfg_next;
	always_comb begin
		cfg_next = cfg_reg;
		if (wr && hit_cfg) begin
			cfg_next = req.wdata & se_regs_pkg::CONFIG_MASK;
		end else if (live_rd) begin
			cfg_next[se_regs_pkg::BIT_ID_REQ] = 1'b0;
		end
	end
	// FIFO levels packed into their fields
	wire logic [31:0] lvl_next = {17'h0, src_free, 1'b0, dst_fill};

	// Register state
	always_ff @(posedge clk or negedge rsn) begin
		if (!rsn) begin
			cfg_reg <= se_regs_pkg::RST_ZERO;
			sts_reg <= se_regs_pkg::RST_ZERO;
			msk_reg <= se_regs_pkg::RST_ZERO;
			leg_reg <= se_regs_pkg::RST_ZERO;
			lvl_reg <= se_regs_pkg::RST_FIFO_LEVEL;
			live_reg <= se_regs_pkg::RST_ZERO;
		end else begin
			cfg_reg <= cfg_next;
			sts_reg <= sts_next;
			live_reg <= live;
			lvl_reg <= lvl_next;
			if (wr && hit_msk) begin
				msk_reg <= req.wdata & se_regs_pkg::STATUS_MASK;
			end
			if (wr && hit_leg) begin
				leg_reg <= req.wdata;
			end
		end
	end

	// Ring pointers; engine advances by one dword descriptor slot
	logic [31:0] cmdr_reg;
	logic [31:0] srcr_reg;
	always_ff @(posedge clk or negedge rsn) begin
		if (!rsn) begin
			cmdr_reg <= se_regs_pkg::RST_ZERO;
			srcr_reg <= se_regs_pkg::RST_ZERO;
		end else begin
			// Software write wins over engine advance
			if (wr && hit_cmdr) begin
				cmdr_reg <= req.wdata & se_regs_pkg::RING_MASK;
			end else if (ring_adv_cmd) begin
				cmdr_reg <= cmdr_reg + 32'h0000_0004;
			end
			if (wr && hit_srcr) begin
				srcr_reg <= req.wdata & se_regs_pkg::RING_MASK;
			end else if (ring_adv_src) begin
				srcr_reg <= srcr_reg + 32'h0000_0004;
			end
		end
	end
	assign cmd_ring_ptr = cmdr_reg;
	assign src_ring_ptr = srcr_reg;

	// Read mux; blocked host reads fall through to zero
	wire logic [31:0] live_view = id_req ? IDENTIFICATION_REQUEST : live_reg;
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_cfg) rd_mux = cfg_reg;
		if (hit_sts) rd_mux = sts_reg;
		if (hit_msk) rd_mux = msk_reg;
		if (hit_live) rd_mux = live_view;
		if (hit_lvl) rd_mux = lvl_reg;
		if (hit_leg) rd_mux = leg_reg;
		if (hit_cmdr) rd_mux = cmdr_reg;
		if (hit_srcr) rd_mux = srcr_reg;
	end

	// Read port and interrupt
	always_ff @(posedge clk or negedge rsn) begin
		if (!rsn) begin
			rdata <= 32'h0000_0000;
			rvalid <= 1'b0;
			irq <= 1'b0;
		end else begin
			rvalid <= rd;
			rdata <= rd ? rd_mux : 32'h0000_0000;
			irq <= |(sts_next & msk_reg);
		end
	end

	// Checks
	a_irq_gate: assert property (@(posedge clk) disable iff (!rsn)
		irq == |($past(sts_next) & $past(msk_reg)))
		else $error("irq does not follow masked status");
	a_sticky_hold: assert property (@(posedge clk) disable iff (!rsn)
		$past(sts_reg[9]) && !$past(sts_clr[9]) |-> sts_reg[9])
		else $error("status bit dropped without clear");
	a_event_sets: assert property (@(posedge clk) disable iff (!rsn)
		ev_dst_overrun |=> sts_reg[se_regs_pkg::BIT_DST_OVERRUN])
		else $error("overrun event not captured");
	a_invalid_sets: assert property (@(posedge clk) disable iff (!rsn)
		ev_invalid_cmd |=> sts_reg[se_regs_pkg::BIT_INVALID_CMD])
		else $error("invalid command not captured");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rsn)
		(sts_reg & ~se_regs_pkg::STATUS_MASK) == 32'h0000_0000)
		else $error("reserved status bit set");
	a_host_blocked: assert property (@(posedge clk) disable iff (!rsn)
		rd && protected_mode && !req.from_cpu |=> rvalid && rdata == 32'h0000_0000)
		else $error("protected host read returned data");
	a_id_read: assert property (@(posedge clk) disable iff (!rsn)
		live_rd && id_req |=> rdata == IDENTIFICATION_REQUEST && !id_req)
		else $error("identification read wrong");
	a_phase_live: assert property (@(posedge clk) disable iff (!rsn)
		src_phase[2] |=> live_reg[se_regs_pkg::BIT_SRC_CMD])
		else $error("source command phase not shown");
	a_ring_align: assert property (@(posedge clk) disable iff (!rsn)
		$past(wr && hit_cmdr) |-> cmdr_reg[1:0] == 2'b00)
		else $error("command ring pointer misaligned");
	a_level_field: assert property (@(posedge clk) disable iff (!rsn)
		1'b1 |=> lvl_reg[14:8] == $past(src_free) && lvl_reg[6:0] == $past(dst_fill))
		else $error("fifo level fields wrong");
endmodule

//--- testbench/test_se_regs.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t: got %h want %h", $time, (a), (b)); end end
module test_se_regs;
	localparam logic [31:0] ID = 32'h0000_0c3c; // Arbitrary value
	logic clk = 1'b0; // Engine clock
	logic rst_n = 1'b0; // Reset, active low
	se_regs_pkg::bus_req_t req = '0; // Register request
	logic [31:0] rdata; // Read data
	logic rvalid; // Read strobe
	logic prot = 1'b0; // Protected mode
	logic e_inv = 1'b0, e_dat = 1'b0, e_ovr = 1'b0; // Engine events
	logic s_rdy = 1'b0, d_rdy = 1'b0, adv_c = 1'b0, adv_s = 1'b0; // Levels and advances
	logic [2:0] s_ph = '0; // Source phase
	logic [1:0] d_ph = '0; // Dest phase
	logic [6:0] s_free = 7'h40, d_fill = 7'h40; // FIFO levels, idle values
	logic [31:0] c_ptr, s_ptr, w; // Pointers and scratch
	logic irq; // Interrupt
	int seed = 69079, mismatches = 0, cmp_count = 0, cycles = 0; // Bench state
	always #5 clk = ~clk;
	se_regs #(.IDENTIFICATION_REQUEST(ID)) i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.rvalid(rvalid), .protected_mode(prot), .ev_invalid_cmd(e_inv), .ev_data_err(e_dat),
		.ev_dst_overrun(e_ovr), .src_rdy(s_rdy), .dst_rdy(d_rdy), .src_phase(s_ph),
		.dst_phase(d_ph), .src_free(s_free), .dst_fill(d_fill), .ring_adv_cmd(adv_c),
		.ring_adv_src(adv_s), .cmd_ring_ptr(c_ptr), .src_ring_ptr(s_ptr), .irq(irq));
	// Watchdog so a hung handshake still reaches the verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	// Live status as the held inputs should show it
	function automatic logic [31:0] live_exp();
		return {16'h0, e_inv, e_dat, s_rdy, d_rdy, 2'b0, e_ovr, 1'b0, s_ph, d_ph[1], 1'b0,
			d_ph[0], 2'b0};
	endfunction
	// FIFO level word from the held counts
	function automatic logic [31:0] fifo_exp();
		return {17'h0, s_free, 1'b0, d_fill};
	endfunction
	// One bus cycle; a gap cycle keeps the strobe from being driven twice in a step
	task automatic acc(input logic wr, g1, cpu, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		req <= {1'b1, wr, g1, cpu, a, d};
		@(negedge clk);
		req <= '0;
	endtask
	// Read and compare; the answer lands one edge after the request
	task automatic rd(input logic g1, cpu, input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, g1, cpu, a, 32'h0);
		`CHK(rvalid, 1'b1)
		`CHK(rdata, e)
	endtask
	// Waits a few cycles for the interrupt path to settle
	task automatic irq_is(input logic e);
		repeat (3) @(negedge clk);
		`CHK(irq, e)
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (3) @(negedge clk);
		// Reset values, plus an unmapped hole
		rd(0, 1, 8'h14, '0);
		rd(0, 1, 8'h10, '0);
		rd(1, 1, 8'h0c, '0);
		rd(1, 1, 8'h1c, '0);
		rd(0, 1, 8'h1c, '0);
		rd(0, 1, 8'h18, 32'h0000_4040);
		rd(0, 1, 8'h44, '0);
		// Random engine conditions; last pass pins the counts at full scale
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			w = $random(seed);
			{e_inv, e_dat, e_ovr, s_rdy, d_rdy, s_ph, d_ph} = w[9:0];
			{s_free, d_fill} = (i == 7) ? 14'h3fff : w[23:10];
			repeat (2) @(negedge clk);
			rd(0, 1, 8'h14, live_exp());
			acc(1, 0, 1, 8'h14, 32'hffff_ffff);
			rd(0, 1, 8'h14, live_exp());
			rd(0, 1, 8'h18, fifo_exp());
		end
		// Quiet conditions, then clear every sticky bit and mask all
		@(negedge clk);
		{e_inv, e_dat, e_ovr, s_rdy, d_rdy, s_ph, d_ph} = '0;
		acc(1, 0, 1, 8'h08, 32'hffff_ffff);
		acc(1, 0, 1, 8'h10, '0);
		// Single overrun pulse must stick
		@(negedge clk) e_ovr = 1'b1;
		@(negedge clk) e_ovr = 1'b0;
		repeat (3) @(negedge clk);
		rd(0, 1, 8'h08, 32'h0000_0200);
		rd(0, 1, 8'h14, '0);
		irq_is(1'b0);
		acc(1, 0, 1, 8'h10, 32'h0000_0200);
		irq_is(1'b1);
		acc(1, 0, 1, 8'h10, 32'h0000_f0f4);
		irq_is(1'b0);
		acc(1, 0, 1, 8'h08, 32'h0000_0200);
		rd(0, 1, 8'h08, '0);
		// Identification only on the next live read
		acc(1, 0, 1, 8'h00, 32'h0000_0020);
		rd(0, 1, 8'h14, ID);
		rd(0, 1, 8'h14, '0);
		// Ring pointers load and step per fetched descriptor
		w = $random(seed) & se_regs_pkg::RING_MASK;
		acc(1, 1, 1, 8'h0c, w);
		acc(1, 1, 1, 8'h1c, ~w & se_regs_pkg::RING_MASK);
		rd(1, 1, 8'h0c, w);
		@(negedge clk) {adv_c, adv_s} = 2'b11;
		@(negedge clk) {adv_c, adv_s} = 2'b00;
		`CHK(c_ptr, w + 32'h4)
		`CHK(s_ptr, (~w & se_regs_pkg::RING_MASK) + 32'h4)
		acc(1, 0, 1, 8'h1c, 32'h0000_0400);
		rd(0, 1, 8'h1c, 32'h0000_0400);
		// Protected mode shuts the host out, processor keeps access
		prot = 1'b1;
		rd(1, 0, 8'h0c, '0);
		acc(1, 1, 0, 8'h0c, 32'h0000_1000);
		rd(1, 1, 8'h0c, w + 32'h4);
		rd(0, 0, 8'h10, '0);
		rd(0, 0, 8'h18, '0);
		acc(1, 0, 0, 8'h10, 32'h0000_0000);
		rd(0, 1, 8'h10, 32'h0000_f0f4);
		end_sim();
	end
endmodule
